// ### design/ppp_pkg.sv
// package for the parallel programming port: command codes, selects, timing
// assumes a 40 MHz core clock; memories live outside behind a simple strobe port
package ppp_pkg;

  localparam int CLK_MHZ = 40;
  localparam int ENTRY_GUARD_NS = 100;
  localparam int ENTRY_GUARD_CYC = (ENTRY_GUARD_NS * CLK_MHZ + 999) / 1000;
  localparam int ENTRY_TOGGLES = 6;
  localparam int ERASE_CYC = 4000;
  localparam int PROG_CYC = 2000;

  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;

  localparam logic [1:0] SEL_LOW = 2'h0;
  localparam logic [1:0] SEL_HIGH = 2'h1;
  localparam logic [1:0] SEL_EXT = 2'h2;
  localparam logic [1:0] SEL_FHI = 2'h3;

  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EEP = 8'h11;
  localparam logic [7:0] CMD_RD_SIG = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EEP = 8'h03;

  localparam logic [7:0] FUSE_LO_RST = 8'hff;
  localparam logic [7:0] FUSE_HI_RST = 8'hff;
  localparam logic [7:0] FUSE_EXT_RST = 8'hff;
  localparam logic [7:0] LOCK_RST = 8'hff;
  localparam int KEEP_EEP_BIT = 3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ERASE = 2'b01,
    ST_PROG = 2'b10
  } ppp_state_type;

  // memory-side request toward the flash/eeprom arrays
  typedef struct packed {
    logic erase_flash;
    logic erase_eep;
    logic wr_flash_page;
    logic wr_eep_page;
    logic [23:0] addr;
  } ppp_mem_req_type;

endpackage : ppp_pkg

// ### design/ppp_port.sv
// parallel programming port: pin decode, command/address/data latches, page buffer
// assumes all pins arrive asynchronously; arrays sit outside and are reached via MEM_*
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - done flag is low during erase or page programming, high otherwise
// - data bus driven only while output-enable pin is low
// - load strobe action code: 00 address, 01 data, 10 command, 11 idle
// - address byte select: 00 low, 01 high, 10 extended, 11 ignored
// - data loading picks low or high byte by the low select bit
// - fuse write selects low/high/extended; reads give fuse lo, lock, ext, fuse hi
// - pattern change within 100 ns after high voltage rejects entry
// - command and address persist across operations
// - write commands: erase, fuses, lock, flash, eeprom decoded
// - read commands: signature, fuse/lock, flash, eeprom decoded
// - commit and output-enable act by loaded command, not action pins
// - erase clears flash, lock, eeprom unless keep fuse; fuses kept
// - erase starts on commit pulse; flag low until done
// - flash words collect in a page buffer written as one page
// - latch pulse stores both data bytes into the page buffer
// - low address bits pick word in page, upper bits pick page
// - commit with select 00 programs buffered page, flag low till done
// - command 00 is a no-op and ends the page session
module ppp_port #(
  parameter int PAGE_WORDS = 128,
  parameter int ERASE_CYCLES = ppp_pkg::ERASE_CYC,
  parameter int PROG_CYCLES = ppp_pkg::PROG_CYC,
  parameter logic [7:0] SIG0 = 8'h5a, // arbitrary identity value
  parameter logic [7:0] SIG1 = 8'h01, // arbitrary identity value
  parameter logic [7:0] SIG2 = 8'h02, // arbitrary identity value
  parameter logic [7:0] CAL_BYTE = 8'h80
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic HV_PRESENT,
  input wire logic LOAD_STROBE,
  input wire logic COMMIT_PULSE_N,
  input wire logic OUT_DRIVE_N,
  input wire logic BUFFER_LATCH_PULSE,
  input wire logic STROBE_ACTION_B1,
  input wire logic STROBE_ACTION_B0,
  input wire logic BYTE_SEL_HI_BIT,
  input wire logic BYTE_SEL_LO_BIT,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  output logic PROG_DONE_FLAG,
  output logic PROG_MODE,
  input wire logic [15:0] MEM_RD_WORD,
  input wire logic [7:0] MEM_RD_EEP,
  output ppp_pkg::ppp_mem_req_type MEM_REQ,
  output logic [15:0] MEM_PAGE_WORD,
  output logic [$clog2(PAGE_WORDS)-1:0] MEM_PAGE_IDX,
  output logic [7:0] FUSE_LO,
  output logic [7:0] FUSE_HI,
  output logic [7:0] FUSE_EXT,
  output logic [7:0] LOCK_BITS
);

  localparam int IW = $clog2(PAGE_WORDS);

  initial begin
    if (PAGE_WORDS < 2 || PAGE_WORDS > 256 || (PAGE_WORDS & (PAGE_WORDS - 1)) != 0) begin
      $error("PAGE_WORDS must be a power of two from 2 to 256");
    end
    // the busy counter is 16 bits and the page must stream out before busy ends
    if (PROG_CYCLES < PAGE_WORDS || PROG_CYCLES > 65535 || ERASE_CYCLES < 1 ||
        ERASE_CYCLES > 65535) begin
      $error("busy cycle counts must fit 16 bits and cover one page");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: stage one is read only by stage two
  localparam int NP = 9;
  logic [NP-1:0] pin_raw, s1_q, s2_q, s3_q;
  logic [7:0] din1_q, din2_q;

  assign pin_raw = {HV_PRESENT, LOAD_STROBE, COMMIT_PULSE_N, OUT_DRIVE_N, BUFFER_LATCH_PULSE,
                    STROBE_ACTION_B1, STROBE_ACTION_B0, BYTE_SEL_HI_BIT, BYTE_SEL_LO_BIT};

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s1_q <= 9'h06c; // idle levels, so no false edge follows reset
      s2_q <= 9'h06c;
      s3_q <= 9'h06c;
      din1_q <= 8'h00;
      din2_q <= 8'h00;
    end else if (CE) begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      din1_q <= DATA_IN;
      din2_q <= din1_q;
    end
  end

  logic hv, strobe_rise, commit_fall, oe_low, latch_rise;
  logic [1:0] action, bsel;
  assign hv = s2_q[8];
  assign strobe_rise = s2_q[7] & ~s3_q[7];
  assign commit_fall = ~s2_q[6] & s3_q[6];
  assign oe_low = ~s2_q[5];
  assign latch_rise = s2_q[4] & ~s3_q[4];
  assign action = s2_q[3:2];
  assign bsel = s2_q[1:0];

  // entry pattern: latch, action b1, action b0, low select
  function automatic logic [3:0] entry_pat(input logic [NP-1:0] p);
    entry_pat = {p[4], p[3], p[2], p[0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // mode entry: count strobe toggles while high voltage is absent, then guard the pattern
  logic [2:0] tog_q;
  logic [7:0] guard_q;
  logic armed_q, mode_q;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tog_q <= 3'h0;
      guard_q <= 8'h00;
      armed_q <= 1'b0;
      mode_q <= 1'b0;
    end else if (CE) begin
      if (!hv) begin
        mode_q <= 1'b0;
        armed_q <= 1'b0;
        guard_q <= 8'h00;
        if (strobe_rise && tog_q < 3'(ppp_pkg::ENTRY_TOGGLES)) begin
          tog_q <= tog_q + 3'h1;
        end
      end else if (!mode_q && !armed_q && s3_q[8] == 1'b0) begin
        // just rose: needs toggles and a zero pattern
        armed_q <= tog_q == 3'(ppp_pkg::ENTRY_TOGGLES) && entry_pat(s2_q) == 4'h0;
        tog_q <= 3'h0;
      end else if (armed_q) begin
        if (entry_pat(s2_q) != 4'h0) begin
          armed_q <= 1'b0;
        end else if (guard_q == 8'(ppp_pkg::ENTRY_GUARD_CYC)) begin
          mode_q <= 1'b1;
          armed_q <= 1'b0;
        end else begin
          guard_q <= guard_q + 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command, address and data latches; kept until reloaded
  logic [7:0] cmd_q, dlo_q, dhi_q;
  logic [23:0] addr_q;
  logic busy;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmd_q <= ppp_pkg::CMD_NOP;
      addr_q <= 24'h000000;
      dlo_q <= 8'h00;
      dhi_q <= 8'h00;
    end else if (CE && mode_q && strobe_rise && !busy) begin
      case (action)
        ppp_pkg::ACT_ADDR: begin
          case (bsel)
            ppp_pkg::SEL_LOW: addr_q[7:0] <= din2_q;
            ppp_pkg::SEL_HIGH: addr_q[15:8] <= din2_q;
            ppp_pkg::SEL_EXT: addr_q[23:16] <= din2_q;
            default: ;
          endcase
        end
        ppp_pkg::ACT_DATA: begin
          if (bsel[0]) dhi_q <= din2_q;
          else dlo_q <= din2_q;
        end
        ppp_pkg::ACT_CMD: cmd_q <= din2_q;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // page buffer filled by the latch pulse, word picked by low address bits
  logic [15:0] page_mem [PAGE_WORDS];
  logic [7:0] eep_mem [PAGE_WORDS];
  logic session_q;
  logic [IW-1:0] widx;
  assign widx = addr_q[IW-1:0];

  always_ff @(posedge CLK) begin
    if (CE && mode_q && latch_rise && !busy) begin
      if (cmd_q == ppp_pkg::CMD_WR_FLASH) page_mem[widx] <= {dhi_q, dlo_q};
      if (cmd_q == ppp_pkg::CMD_WR_EEP) eep_mem[widx] <= dlo_q;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      session_q <= 1'b0;
    end else if (CE && !busy) begin
      // refused loads while busy must not end the session either
      if (mode_q && latch_rise) begin
        session_q <= 1'b1; // set wins over a nop load in the same cycle
      end else if (mode_q && strobe_rise && action == ppp_pkg::ACT_CMD &&
                   din2_q == ppp_pkg::CMD_NOP) begin
        session_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // commit execution: erase, page write, fuse and lock writes
  ppp_pkg::ppp_state_type st_q;
  logic [15:0] cnt_q;
  logic [IW-1:0] xfer_q;
  logic page_ok, is_eep_q;
  assign busy = st_q != ppp_pkg::ST_IDLE;
  assign page_ok = bsel == ppp_pkg::SEL_LOW && session_q;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= ppp_pkg::ST_IDLE;
      cnt_q <= 16'h0000;
      xfer_q <= '0;
      is_eep_q <= 1'b0;
      MEM_REQ <= '0;
      FUSE_LO <= ppp_pkg::FUSE_LO_RST;
      FUSE_HI <= ppp_pkg::FUSE_HI_RST;
      FUSE_EXT <= ppp_pkg::FUSE_EXT_RST;
      LOCK_BITS <= ppp_pkg::LOCK_RST;
      MEM_PAGE_WORD <= 16'h0000;
      MEM_PAGE_IDX <= '0;
    end else if (CE) begin
      MEM_REQ.wr_flash_page <= 1'b0;
      MEM_REQ.wr_eep_page <= 1'b0;
      case (st_q)
        ppp_pkg::ST_IDLE: begin
          MEM_REQ.erase_flash <= 1'b0;
          MEM_REQ.erase_eep <= 1'b0;
          if (mode_q && commit_fall) begin
            case (cmd_q)
              ppp_pkg::CMD_ERASE: begin
                st_q <= ppp_pkg::ST_ERASE;
                cnt_q <= 16'(ERASE_CYCLES);
                MEM_REQ.erase_flash <= 1'b1;
                MEM_REQ.erase_eep <= FUSE_HI[ppp_pkg::KEEP_EEP_BIT];
              end
              ppp_pkg::CMD_WR_FLASH, ppp_pkg::CMD_WR_EEP: begin
                if (page_ok) begin
                  st_q <= ppp_pkg::ST_PROG;
                  cnt_q <= 16'(PROG_CYCLES);
                  xfer_q <= '0;
                  is_eep_q <= cmd_q[0];
                  MEM_REQ.addr <= {addr_q[23:IW], {IW{1'b0}}};
                end
              end
              ppp_pkg::CMD_WR_FUSE: begin
                case (bsel)
                  ppp_pkg::SEL_LOW: FUSE_LO <= dlo_q;
                  ppp_pkg::SEL_HIGH: FUSE_HI <= dlo_q;
                  ppp_pkg::SEL_EXT: FUSE_EXT <= dlo_q;
                  default: ;
                endcase
              end
              ppp_pkg::CMD_WR_LOCK: LOCK_BITS <= LOCK_BITS & dlo_q; // only programs
              default: ;
            endcase
          end
        end
        ppp_pkg::ST_ERASE: begin
          // lock bits clear only once the array is fully erased
          if (cnt_q == 16'h0001) begin
            LOCK_BITS <= ppp_pkg::LOCK_RST;
            st_q <= ppp_pkg::ST_IDLE;
          end
          cnt_q <= cnt_q - 16'h0001;
        end
        ppp_pkg::ST_PROG: begin
          // page words stream out once in the first cycles, then the write time elapses
          if (cnt_q > 16'(PROG_CYCLES - PAGE_WORDS)) begin
            MEM_PAGE_IDX <= xfer_q;
            MEM_PAGE_WORD <= is_eep_q ? {8'h00, eep_mem[xfer_q]} : page_mem[xfer_q];
            MEM_REQ.wr_flash_page <= ~is_eep_q;
            MEM_REQ.wr_eep_page <= is_eep_q;
            xfer_q <= xfer_q + 1'b1;
          end
          if (cnt_q == 16'h0001) st_q <= ppp_pkg::ST_IDLE;
          cnt_q <= cnt_q - 16'h0001;
        end
        default: st_q <= ppp_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status outputs
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PROG_DONE_FLAG <= 1'b1;
      PROG_MODE <= 1'b0;
    end else if (CE) begin
      PROG_DONE_FLAG <= !busy && !(mode_q && commit_fall && (cmd_q == ppp_pkg::CMD_ERASE ||
                        ((cmd_q == ppp_pkg::CMD_WR_FLASH || cmd_q == ppp_pkg::CMD_WR_EEP)
                         && page_ok)));
      PROG_MODE <= mode_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read-back mux, driven by the loaded command while output enable is low
  function automatic logic [7:0] read_mux(input logic [7:0] cmd, input logic [1:0] s,
                                          input logic [7:0] a, input logic [15:0] w,
                                          input logic [7:0] e, input logic [7:0] fl,
                                          input logic [7:0] fh, input logic [7:0] fx,
                                          input logic [7:0] lk);
    read_mux = 8'h00;
    case (cmd)
      ppp_pkg::CMD_RD_FLASH: read_mux = s[0] ? w[15:8] : w[7:0];
      ppp_pkg::CMD_RD_EEP: read_mux = e;
      ppp_pkg::CMD_RD_SIG: begin
        if (s[0]) read_mux = CAL_BYTE;
        else if (a == 8'h00) read_mux = SIG0;
        else if (a == 8'h01) read_mux = SIG1;
        else if (a == 8'h02) read_mux = SIG2;
      end
      ppp_pkg::CMD_RD_FUSE: begin
        case (s)
          ppp_pkg::SEL_LOW: read_mux = fl;
          ppp_pkg::SEL_HIGH: read_mux = lk;
          ppp_pkg::SEL_EXT: read_mux = fx;
          default: read_mux = fh;
        endcase
      end
      default: read_mux = 8'h00;
    endcase
  endfunction : read_mux

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DATA_OUT <= 8'h00;
      DATA_OE <= 1'b0;
    end else if (CE) begin
      DATA_OE <= mode_q && oe_low;
      DATA_OUT <= read_mux(cmd_q, bsel, addr_q[7:0], MEM_RD_WORD, MEM_RD_EEP,
                           FUSE_LO, FUSE_HI, FUSE_EXT, LOCK_BITS);
    end
  end

endmodule : ppp_port

`default_nettype wire

// ### testbench/ppp_port_properties.sv
// checker for the parallel programming port, bound to every ppp_port
// assumes one clock domain with asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module ppp_port_props #(
  parameter int ERASE_CYCLES = 4000,
  parameter int PROG_CYCLES = 2000
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HV_PRESENT,
  input wire logic COMMIT_PULSE_N,
  input wire logic OUT_DRIVE_N,
  input wire logic BUFFER_LATCH_PULSE,
  input wire logic STROBE_ACTION_B1,
  input wire logic STROBE_ACTION_B0,
  input wire logic BYTE_SEL_LO_BIT,
  input wire logic DATA_OE,
  input wire logic PROG_DONE_FLAG,
  input wire logic PROG_MODE,
  input wire ppp_pkg::ppp_mem_req_type MEM_REQ,
  input wire logic [7:0] FUSE_LO,
  input wire logic [7:0] FUSE_HI,
  input wire logic [7:0] FUSE_EXT
);
  localparam int BUSY_MAX = (ERASE_CYCLES > PROG_CYCLES ? ERASE_CYCLES : PROG_CYCLES) + 8;
  logic pat_zero;
  logic [3:0] since_q;
  logic [15:0] busy_q;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  assign pat_zero = !(BUFFER_LATCH_PULSE | STROBE_ACTION_B1 | STROBE_ACTION_B0 | BYTE_SEL_LO_BIT);
  // cycles since commit was last low; a busy stretch needs a recent cause
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) since_q <= 4'hf;
    else if (!COMMIT_PULSE_N) since_q <= 4'h0;
    else if (since_q != 4'hf) since_q <= since_q + 4'h1;
  end
  // busy length, saturating so a stuck flag cannot wrap back to legal
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) busy_q <= 16'h0;
    else if (PROG_DONE_FLAG) busy_q <= 16'h0;
    else if (busy_q != 16'hffff) busy_q <= busy_q + 16'h1;
  end
  ////////////////////////////////////////
  property p_oe_quiet; OUT_DRIVE_N [*8] |-> !DATA_OE; endproperty
  a_oe_quiet: assert property (p_oe_quiet) else $error("bus driven while disabled");
  property p_busy_hold; $fell(PROG_DONE_FLAG) |=> !PROG_DONE_FLAG [*8]; endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy too short");
  property p_busy_len; busy_q <= BUSY_MAX; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy never ends");
  property p_busy_cause; $fell(PROG_DONE_FLAG) |-> since_q < 4'hc; endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without commit");
  property p_mode_entry;
    $rose(PROG_MODE) |-> HV_PRESENT && $past(HV_PRESENT, 4) && $past(pat_zero, 4);
  endproperty
  a_mode_entry: assert property (p_mode_entry) else $error("bad mode entry");
  property p_mode_hold; PROG_MODE && HV_PRESENT |=> PROG_MODE; endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode lost");
  property p_wr_busy; MEM_REQ.wr_flash_page |-> !PROG_DONE_FLAG; endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("page write while ready");
  property p_erase_busy; MEM_REQ.erase_flash |-> !PROG_DONE_FLAG; endproperty
  a_erase_busy: assert property (p_erase_busy) else $error("erase while ready");
  property p_fuse_kept;
    MEM_REQ.erase_flash |=> $stable(FUSE_LO) && $stable(FUSE_HI) && $stable(FUSE_EXT);
  endproperty
  a_fuse_kept: assert property (p_fuse_kept) else $error("fuse moved in erase");
  property p_eep_keep; MEM_REQ.erase_eep |-> FUSE_HI[3]; endproperty
  a_eep_keep: assert property (p_eep_keep) else $error("eeprom erased though kept");
  c_erase: cover property (MEM_REQ.erase_flash);
  c_page: cover property (MEM_REQ.wr_flash_page);
  c_read: cover property ($rose(DATA_OE));
endmodule : ppp_port_props
bind ppp_port ppp_port_props #(.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES)) u_props (
  .CLK, .RST_N, .HV_PRESENT, .COMMIT_PULSE_N, .OUT_DRIVE_N, .BUFFER_LATCH_PULSE,
  .STROBE_ACTION_B1, .STROBE_ACTION_B0, .BYTE_SEL_LO_BIT, .DATA_OE, .PROG_DONE_FLAG,
  .PROG_MODE, .MEM_REQ, .FUSE_LO, .FUSE_HI, .FUSE_EXT);
`default_nettype wire

// ### testbench/ppp_programmer.sv
// external programmer model: drives strobes, selects and the data bus
// assumes the port samples on rising edges; pins move on falling edges
`timescale 1ns/1ps
`default_nettype none
module ppp_programmer (
  input wire logic clk,
  output logic hv,
  output logic ld,
  output logic cm_n,
  output logic oe_n,
  output logic lat,
  output logic [1:0] act,
  output logic [1:0] sel,
  output logic [7:0] pd
);
  // idle pins, entry pattern already zero
  initial begin
    {hv, ld, lat, act, sel, pd} = '0;
    {cm_n, oe_n} = 2'b11;
  end
  ////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // one load strobe, each phase 10 cycles so the port never sees a short pulse
  task automatic load(input logic [1:0] a, input logic [1:0] s, input logic [7:0] d);
    act = a;
    sel = s;
    pd = d;
    cyc(10);
    ld = 1'b1;
    cyc(10);
    ld = 1'b0;
    cyc(10);
  endtask : load
  task automatic latch();
    lat = 1'b1;
    cyc(10);
    lat = 1'b0;
    cyc(10);
  endtask : latch
  task automatic commit();
    cm_n = 1'b0;
    cyc(10);
    cm_n = 1'b1;
    cyc(2);
  endtask : commit
  // read cycle; programmer value inverted so a stale programmer value cannot pass for data
  task automatic drive(input logic [1:0] s, input logic on);
    sel = s;
    pd = ~pd;
    oe_n = !on;
    cyc(8);
  endtask : drive
  // six toggles, zero pattern held, then voltage and settle time
  task automatic enter();
    {act, sel, lat} = '0;
    repeat (6) begin
      ld = 1'b1;
      cyc(10);
      ld = 1'b0;
      cyc(10);
    end
    hv = 1'b1;
    cyc(2000);
  endtask : enter
endmodule : ppp_programmer
`default_nettype wire

// ### testbench/parallel_program_port_test.sv
// self-checking bench for ppp_port with the programmer model
// assumes ERASE_CYCLES and PROG_CYCLES shortened to 50, pages of 8 words
`timescale 1ns/1ps
`default_nettype none
module parallel_program_port_test;
  typedef struct packed {
    logic [7:0] cmd;
    logic [1:0] s;
    logic [7:0] exp;
  } ppp_row_type;
  logic clk, rst_n, ce, hv, ld, cm_n, oe_n, lat, oe, done, pmode, er_f, er_e;
  logic [1:0] act, sel;
  logic [7:0] pd, bus, dout, fl, fh, fx, lk, prev;
  logic [15:0] pw;
  logic [2:0] pidx;
  logic [15:0] pg [8];
  ppp_pkg::ppp_mem_req_type req;
  int n_fail, samples_checked, busy_cyc, n_wr;
  ppp_row_type rows [9];
  assign bus = oe ? dout : pd;
  ppp_programmer p (.clk(clk), .hv(hv), .ld(ld), .cm_n(cm_n), .oe_n(oe_n), .lat(lat),
    .act(act), .sel(sel), .pd(pd));
  ppp_port #(.PAGE_WORDS(8), .ERASE_CYCLES(50), .PROG_CYCLES(50)) dut (.CLK(clk), .RST_N(rst_n),
    .CE(ce), .HV_PRESENT(hv), .LOAD_STROBE(ld), .COMMIT_PULSE_N(cm_n), .OUT_DRIVE_N(oe_n),
    .BUFFER_LATCH_PULSE(lat), .STROBE_ACTION_B1(act[1]), .STROBE_ACTION_B0(act[0]),
    .BYTE_SEL_HI_BIT(sel[1]), .BYTE_SEL_LO_BIT(sel[0]), .DATA_IN(bus), .DATA_OUT(dout),
    .DATA_OE(oe), .PROG_DONE_FLAG(done), .PROG_MODE(pmode), .MEM_RD_WORD(16'h1234),
    .MEM_RD_EEP(8'h77), .MEM_REQ(req), .MEM_PAGE_WORD(pw), .MEM_PAGE_IDX(pidx),
    .FUSE_LO(fl), .FUSE_HI(fh), .FUSE_EXT(fx), .LOCK_BITS(lk));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // what the arrays would receive
  always @(posedge clk) begin
    if (done !== 1'b1) busy_cyc++;
    if (req.wr_flash_page) pg[pidx] <= pw;
    if (req.wr_flash_page) n_wr++;
    if (req.erase_flash) er_f <= 1'b1;
    if (req.erase_eep) er_e <= 1'b1;
  end
  ////////////////////////////////////////
  task automatic results();
    if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  task automatic check_v(input string what, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : check_v
  // commit then wait for ready; mode 1 wants a busy stretch, 2 wants none
  task automatic run_commit(input int mode);
    int i;
    busy_cyc = 0;
    p.commit();
    for (i = 0; i < 400 && done !== 1'b1; i++) @(negedge clk);
    if (i == 400) begin
      n_fail++;
      results();
    end
    if (mode == 1) check_v("busy span", 16'h1, {15'h0, busy_cyc inside {[50:60]}});
    if (mode == 2) check_v("busy span", 16'h0, busy_cyc[15:0]);
  endtask : run_commit
  ////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    {er_f, er_e} = 2'b00;
    n_fail = 0;
    samples_checked = 0;
    busy_cyc = 0;
    n_wr = 0;
    ce = 1'b1;
    prev = 8'hff;
    rows = '{'{8'h04, 2'h0, 8'h12}, '{8'h04, 2'h1, 8'hfc}, '{8'h04, 2'h2, 8'h56},
      '{8'h04, 2'h3, 8'h37}, '{8'h02, 2'h0, 8'h34}, '{8'h02, 2'h1, 8'h12},
      '{8'h03, 2'h0, 8'h77}, '{8'h08, 2'h0, 8'h5a}, '{8'h08, 2'h1, 8'h80}};
    repeat (4) @(negedge clk);
    check_v("reset flags", 16'h4, {13'h0, done, oe, pmode});
    check_v("reset fuses", 16'hffff, {fl, fh});
    rst_n = 1'b1;
    p.enter();
    check_v("mode", 16'h1, {15'h0, pmode});
    p.load(2'h2, 2'h0, 8'h55);
    run_commit(2);
    p.load(2'h2, 2'h0, 8'h40);
    p.load(2'h1, 2'h0, 8'h00);
    p.load(2'h3, 2'h3, 8'h00);
    run_commit(0);
    check_v("reserved fuse", 16'hffff, {fl, fh});
    for (int i = 0; i < 3; i++) begin
      p.load(2'h1, 2'h0, rows[i == 1 ? 3 : i].exp);
      p.load(2'h3, i[1:0], 8'h00);
      run_commit(0);
    end
    check_v("fuses", 16'h1237, {fl, fh});
    check_v("ext fuse", 16'h0056, {8'h0, fx});
    p.load(2'h2, 2'h0, 8'h20);
    p.load(2'h1, 2'h0, 8'hfc);
    run_commit(0);
    check_v("lock", 16'h00fc, {8'h0, lk});
    p.load(2'h0, 2'h0, 8'h00);
    // table of reads; a command is loaded only when it changes
    foreach (rows[i]) begin
      if (rows[i].cmd != prev) p.load(2'h2, 2'h0, rows[i].cmd);
      prev = rows[i].cmd;
      p.drive(rows[i].s, 1'b1);
      check_v("read", {7'h0, 1'b1, rows[i].exp}, {7'h0, oe, dout});
      p.drive(rows[i].s, 1'b0);
      check_v("released", 16'h0, {15'h0, oe});
    end
    // frozen port must ignore a whole erase sequence
    ce = 1'b0;
    p.load(2'h2, 2'h0, 8'h80);
    p.commit();
    ce = 1'b1;
    p.cyc(8);
    check_v("frozen", 16'h5, {13'h0, done, er_f, pmode});
    p.load(2'h2, 2'h0, 8'h80);
    run_commit(1);
    check_v("erase", 16'h2, {14'h0, er_f, er_e});
    check_v("erase lock fuse", 16'hff37, {lk, fh});
    p.load(2'h2, 2'h0, 8'h10);
    for (int i = 0; i < 2; i++) begin
      p.load(2'h0, 2'h0, i == 0 ? 8'h0d : 8'h0e);
      p.load(2'h1, 2'h0, i == 0 ? 8'hb2 : 8'hd4);
      p.load(2'h1, 2'h1, i == 0 ? 8'ha1 : 8'hc3);
      p.latch();
    end
    p.load(2'h3, 2'h0, 8'h00);
    run_commit(1);
    check_v("page word", 16'ha1b2, pg[5]);
    check_v("page word", 16'hc3d4, pg[6]);
    check_v("page base", 16'h0008, req.addr[15:0]);
    check_v("page pulses", 16'h0008, n_wr[15:0]);
    p.load(2'h2, 2'h0, 8'h00);
    p.load(2'h2, 2'h0, 8'h10);
    run_commit(2);
    results();
  end
endmodule : parallel_program_port_test
`default_nettype wire
